// [bench/mcu_reset_sequencer_tb.sv]
// Self-checking bench for the reset sequencer
`timescale 1ns/1ns
module mcu_reset_sequencer_tb;
    logic clk = 0, rst = 1, press = 0, reset_pin_n_i, reset_pin_n_o;
    logic reset_pin_oe, supply_rise = 0, watchdog_expired = 0;
    logic lvd_enable = 0, supply_above_rise = 1, supply_above_fall = 1;
    logic main_osc_running = 1, aux_osc_active = 0, stop_mode = 0;
    logic return_from_interrupt = 0, irq_pending = 0, core_reset;
    logic io_force_pullup, osc_start, main_osc_off_bit, stack_clear;
    logic pc_load, nmi_mode, service_pending, periph_reset, wdog_reinit;
    logic [11:0] pc_value;
    logic [7:0] port_reset_val, ar_ctrl0_reset_val, ar_mode_reset_val;
    logic [7:0] misc_reset_val, wdog_reset_val;
    int err_total = 0, total_checks = 0, n;
    mcu_reset_sequencer dut_u (.clk, .rst, .reset_pin_n_i, .reset_pin_n_o,
        .reset_pin_oe, .supply_rise, .watchdog_expired, .lvd_enable,
        .supply_above_rise, .supply_above_fall, .main_osc_running,
        .aux_osc_active, .stop_mode, .return_from_interrupt, .irq_pending,
        .core_reset, .io_force_pullup, .osc_start, .main_osc_off_bit,
        .stack_clear, .pc_load, .pc_value, .nmi_mode, .service_pending,
        .periph_reset, .port_reset_val, .ar_ctrl0_reset_val,
        .ar_mode_reset_val, .misc_reset_val, .wdog_reset_val, .wdog_reinit);
    reset_board board_u (.press(press), .dev_oe(reset_pin_oe),
        .dev_out(reset_pin_n_o), .pin_level(reset_pin_n_i));
    initial
    begin
        forever #2 clk = !clk;
    end
    task automatic chk_bit(string nm, logic e, logic g);
        total_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk_val(string nm, logic [11:0] e, logic [11:0] g);
        total_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic tick(int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // Counts cycles until the init pulse, then judges the init state
    task automatic wait_init(string nm);
        n = 0;
        while (pc_load !== 1'b1)
        begin
            tick(1);
            n++;
            if (n > 9000)
            begin
                chk_bit({nm, " init timeout"}, 1'b1, 1'b0);
                tally_and_finish();
            end
        end
        chk_bit("delay length", 1'b1, n >= 4096 && n <= 4110);
        chk_val("pc_value", 12'hFFE, pc_value);
        chk_bit("stack_clear", 1'b1, stack_clear);
        chk_bit("core_reset", 1'b0, core_reset);
        chk_bit("nmi_mode", 1'b1, nmi_mode);
        chk_bit("main_osc_off_bit", 1'b0, main_osc_off_bit);
        chk_val("port", 12'h000, {4'h0, port_reset_val});
        chk_val("ar_ctrl0", 12'h002, {4'h0, ar_ctrl0_reset_val});
        chk_val("ar_mode", 12'h000, {4'h0, ar_mode_reset_val});
        chk_val("misc", 12'h000, {4'h0, misc_reset_val});
        chk_val("wdog", 12'h0FE, {4'h0, wdog_reset_val});
        $display("test %s done", nm);
    endtask
    // Short pin pulse in stop mode still gives a full delayed reset
    task automatic pin_pulse();
        @(posedge clk);
        stop_mode <= 1;
        press <= 1;
        #1;
        chk_bit("async core_reset", 1'b1, core_reset);
        chk_bit("io_force_pullup", 1'b1, io_force_pullup);
        tick(1);
        press <= 0;
        tick(2);
        chk_bit("osc_start", 1'b1, osc_start);
        stop_mode <= 0;
        wait_init("pin pulse");
    endtask
    // Supply-rise and watchdog levels each hold reset and drive the pin
    task automatic internal_src(int s);
        @(posedge clk);
        supply_rise <= (s == 0);
        watchdog_expired <= (s == 1);
        tick(4);
        chk_bit("core_reset", 1'b1, core_reset);
        chk_bit("reset_pin_oe", 1'b1, reset_pin_oe);
        chk_bit("reset_pin level", 1'b0, reset_pin_n_i);
        chk_bit("wdog_reinit", 1'b1, wdog_reinit);
        supply_rise <= 0;
        watchdog_expired <= 0;
        wait_init(s == 0 ? "supply rise" : "watchdog");
    endtask
    task automatic low_voltage();
        @(posedge clk);
        lvd_enable <= 1;
        supply_above_rise <= 0;
        supply_above_fall <= 0;
        tick(20);
        chk_bit("lvd core_reset", 1'b1, core_reset);
        supply_above_fall <= 1;
        tick(4200);
        chk_bit("between refs rising", 1'b1, core_reset);
        supply_above_rise <= 1;
        wait_init("lvd rise");
        supply_above_rise <= 0;
        tick(20);
        chk_bit("between refs falling", 1'b0, core_reset);
        supply_above_fall <= 0;
        tick(4);
        chk_bit("below fall ref", 1'b1, reset_pin_oe);
        supply_above_fall <= 1;
        supply_above_rise <= 1;
        wait_init("lvd drop");
    endtask
    task automatic init_return();
        irq_pending <= 1;
        return_from_interrupt <= 1;
        tick(1);
        chk_bit("service_pending", 1'b1, service_pending);
        chk_bit("nmi_mode cleared", 1'b0, nmi_mode);
        return_from_interrupt <= 0;
        tick(1);
        return_from_interrupt <= 1;
        tick(1);
        chk_bit("return outside init", 1'b0, service_pending);
        return_from_interrupt <= 0;
        tick(1);
        irq_pending <= 0;
        $display("test init return done");
    endtask
    initial
    begin
        tick(20);
        rst <= 0;
        wait_init("power on");
        init_return();
        pin_pulse();
        internal_src(0);
        internal_src(1);
        low_voltage();
        tally_and_finish();
    end
endmodule

// [bench/reset_board.sv]
// Board-side reset circuit: push button on the open-drain reset pin
`timescale 1ns/1ns
module reset_board (
    input wire logic press, // Button held, pulls pin low
    input wire logic dev_oe, // Device pulls pin low
    input wire logic dev_out, // Device drive level
    output logic pin_level // Resolved pin level
);
    // Only pulls low or lets go; the internal pull-up gives the high
    assign pin_level = !press && !(dev_oe && !dev_out);
endmodule

// [src/mcu_reset_sequencer.sv]
// Reset source merger, stabilisation delay and init sequence control
// Contract
// - Four sources merge into one reset
// - Pin active low, held low holds reset
// - Delay appended so short pulses reset fully
// - Pin reset halts core, pulls I/O, restarts osc
// - Release waits for delay after pin high
// - Stop mode pin reset starts oscillator too
// - Supply rise holds reset, no execution
// - Delay counted once oscillator runs
// - Watchdog expiry asserts reset, reinits watchdog
// - Watchdog reset uses full delay
// - Low voltage holds static reset when enabled
// - Falling threshold below rising threshold
// - Internal sources drive reset pin low
// - Clear stack, load PC from 0FFEh
// - Set interrupt flag after reset
// - Return from interrupt ends init mode
// - Port registers clear to 00h
// - Timer control zero loads 02h
// - Timer mode register clears to 00h
// - Miscellaneous register clears to 00h
// - Watchdog register loads 0FEh
// - Reset clears main oscillator off bit
// - Aux oscillator clocks power-up delay
`timescale 1ns/1ns
module mcu_reset_sequencer (
    input wire logic clk, // Oscillator clock, aux at power-on
    input wire logic rst, // Power-on detector pulse, sync high
    input wire logic reset_pin_n_i, // Reset pin input level
    output logic reset_pin_n_o, // Reset pin output level (low)
    output logic reset_pin_oe, // Reset pin drive enable
    input wire logic supply_rise, // Supply-rise detector active
    input wire logic watchdog_expired, // Watchdog end of count
    input wire logic lvd_enable, // Low-voltage option selected
    input wire logic supply_above_rise, // Supply over rising ref
    input wire logic supply_above_fall, // Supply over falling ref
    input wire logic main_osc_running, // Main oscillator running
    input wire logic aux_osc_active, // Aux oscillator clocking us
    input wire logic stop_mode, // Core is in stop mode
    input wire logic return_from_interrupt, // Core executed return
    input wire logic irq_pending, // Maskable interrupt pending
    output logic core_reset, // Core held in reset
    output logic io_force_pullup, // I/O forced to pulled-up inputs
    output logic osc_start, // Request main oscillator start
    output logic main_osc_off_bit, // Oscillator-off control bit
    output logic stack_clear, // Stack reset pulse
    output logic pc_load, // Load PC pulse
    output logic [11:0] pc_value, // Reset vector
    output logic nmi_mode, // Interrupt flag set (init mode)
    output logic service_pending, // Pending irq taken on return
    output logic periph_reset, // Peripheral reset level, registered from HOLD or DELAY
    output logic [7:0] port_reset_val, // Port registers value
    output logic [7:0] ar_ctrl0_reset_val, // AR ctrl0 value
    output logic [7:0] ar_mode_reset_val, // AR mode value
    output logic [7:0] misc_reset_val, // Misc register value
    output logic [7:0] wdog_reset_val, // Watchdog register value
    output logic wdog_reinit // Watchdog counter reinit
);
    typedef enum logic [1:0] {HOLD, DELAY, INIT, RUN} state_e;

    // Core and peripherals stay held while waiting or counting the delay
    function automatic logic held_state(state_e s);
        logic h;
        h = (s == HOLD) || (s == DELAY);
        return h;
    endfunction

    state_e state;
    state_e next_state;
    logic pin_low_sync;
    logic pin_sync;
    logic lvd_ok;
    logic internal_src;
    logic any_src;
    logic [rst_seq_pkg::CNT_W-1:0] delay_cnt;
    logic delay_done;

    sync2 u_pin_sync (
        .clk(clk),
        .rst(rst),
        .rst_val(1'b1),
        .d(reset_pin_n_i),
        .q(pin_sync)
    );
    assign pin_low_sync = ~pin_sync;

    // Hysteresis comparator on the supply level
    always_ff @(posedge clk)
    begin
        if (rst)
            lvd_ok <= 1'b0;
        else if (!supply_above_fall)
            lvd_ok <= 1'b0;
        else if (supply_above_rise)
            lvd_ok <= 1'b1;
    end

    assign internal_src = supply_rise | watchdog_expired
        | (lvd_enable & ~lvd_ok);
    assign any_src = internal_src | pin_low_sync;

    assign reset_pin_n_o = 1'b0;
    // Wired-AND: only ever pull low while rst or an internal source holds
    assign reset_pin_oe = rst | internal_src;

    // Counting needs a real clock; aux oscillator also counts at power-up
    assign delay_done = (delay_cnt ==
        rst_seq_pkg::CNT_W'(rst_seq_pkg::STAB_CYCLES - 1));

    always_comb
    begin
        next_state = state;
        case (state)
            HOLD:
                if (!any_src)
                    next_state = DELAY;
            DELAY:
                if (any_src)
                    next_state = HOLD;
                else if (delay_done && main_osc_running)
                    next_state = INIT;
            INIT:
                if (any_src)
                    next_state = HOLD;
                else if (return_from_interrupt)
                    next_state = RUN;
            RUN:
                if (any_src)
                    next_state = HOLD;
            default:
                next_state = HOLD;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            state <= HOLD;
        else
            state <= next_state;
    end

    always_ff @(posedge clk)
    begin
        if (rst || state != DELAY)
            delay_cnt <= '0;
        else if ((main_osc_running || aux_osc_active) && !delay_done)
            delay_cnt <= delay_cnt + 1'b1;
    end

    // Immediate pin path bypasses the synchroniser
    assign core_reset = rst | ~reset_pin_n_i
        | held_state(state);
    assign io_force_pullup = core_reset;
    assign osc_start = core_reset;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stack_clear <= 1'b0;
            pc_load <= 1'b0;
            pc_value <= rst_seq_pkg::RESET_VECTOR;
        end
        else
        begin
            stack_clear <= (state == DELAY) && (next_state == INIT);
            pc_load <= (state == DELAY) && (next_state == INIT);
            pc_value <= rst_seq_pkg::RESET_VECTOR;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            nmi_mode <= 1'b1;
            service_pending <= 1'b0;
        end
        else
        begin
            nmi_mode <= (next_state != RUN);
            service_pending <= (state == INIT) && return_from_interrupt
                && irq_pending && !any_src;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            main_osc_off_bit <= 1'b0;
            periph_reset <= 1'b1;
            wdog_reinit <= 1'b1;
        end
        else
        begin
            main_osc_off_bit <= 1'b0;
            periph_reset <= held_state(state);
            wdog_reinit <= (state == HOLD);
        end
    end

    always_ff @(posedge clk)
    begin
        port_reset_val <= rst_seq_pkg::PORT_RESET;
        ar_ctrl0_reset_val <= rst_seq_pkg::AR_CTRL0_RESET;
        ar_mode_reset_val <= rst_seq_pkg::AR_MODE_RESET;
        misc_reset_val <= rst_seq_pkg::MISC_RESET;
        wdog_reset_val <= rst_seq_pkg::WDOG_RESET;
    end

    a_wdog_resets: assert property (@(posedge clk) disable iff (rst)
        watchdog_expired |=> state == HOLD)
        else $error("watchdog expiry did not reset");
    a_pin_drive: assert property (@(posedge clk) disable iff (rst)
        internal_src |-> reset_pin_oe && !reset_pin_n_o)
        else $error("reset pin not pulled low");
    a_pin_hold: assert property (@(posedge clk) disable iff (rst)
        !pin_sync |=> core_reset)
        else $error("core ran with pin low");
    a_delay_full: assert property (@(posedge clk) disable iff (rst)
        (state == DELAY && next_state == INIT) |-> delay_done)
        else $error("init began before delay end");
    a_init_pulse: assert property (@(posedge clk) disable iff (rst)
        $rose(state == INIT) |-> pc_load && stack_clear)
        else $error("no vector load at init");
    a_nmi_init: assert property (@(posedge clk) disable iff (rst)
        state == INIT |-> nmi_mode)
        else $error("interrupt flag clear in init");
    a_return_from_interrupt_run: assert property (@(posedge clk) disable iff (rst)
        (state == INIT && return_from_interrupt && !any_src)
        |=> state == RUN ##1 !nmi_mode)
        else $error("return did not end init");
    a_lvd_hold: assert property (@(posedge clk) disable iff (rst)
        (lvd_enable && !supply_above_fall) |=> ##1 core_reset)
        else $error("low supply did not hold reset");
    a_osc_on: assert property (@(posedge clk) disable iff (rst)
        $fell(core_reset) |-> !main_osc_off_bit)
        else $error("oscillator off after reset");
    a_wdog_val: assert property (@(posedge clk) disable iff (rst)
        periph_reset |-> wdog_reset_val == 8'hFE
        && ar_ctrl0_reset_val == 8'h02)
        else $error("wrong peripheral reset value");
    // Stop mode takes the same path as run mode
    a_stop_osc: assert property (@(posedge clk) disable iff (rst)
        (stop_mode && !pin_sync) |=> osc_start)
        else $error("stop mode pin reset kept oscillator off");
    a_rise_hold: assert property (@(posedge clk) disable iff (rst)
        supply_rise |=> core_reset && io_force_pullup)
        else $error("supply rise did not hold reset");
    a_pullup_held: assert property (@(posedge clk) disable iff (rst)
        core_reset |-> io_force_pullup && osc_start)
        else $error("I/O not pulled up in reset");
    a_delay_osc: assert property (@(posedge clk) disable iff (rst)
        (state == DELAY && !main_osc_running) |=> state != INIT)
        else $error("init began without main oscillator");
    a_wdog_delay: assert property (@(posedge clk) disable iff (rst)
        watchdog_expired |=> !pc_load)
        else $error("watchdog reset skipped the delay");
    a_vector_val: assert property (@(posedge clk) disable iff (rst)
        pc_load |-> pc_value == rst_seq_pkg::RESET_VECTOR)
        else $error("wrong reset vector");
    a_port_clear: assert property (@(posedge clk) disable iff (rst)
        periph_reset |-> port_reset_val == rst_seq_pkg::PORT_RESET)
        else $error("port reset value wrong");
    a_ar_mode: assert property (@(posedge clk) disable iff (rst)
        periph_reset |-> ar_mode_reset_val == 8'h00)
        else $error("timer mode reset value wrong");
    a_misc_clear: assert property (@(posedge clk) disable iff (rst)
        periph_reset |-> misc_reset_val == 8'h00)
        else $error("misc reset value wrong");
endmodule

// [src/rst_seq_pkg.sv]
// Shared constants for the reset sequencer
package rst_seq_pkg;
    localparam int STAB_CYCLES = 4096;
    localparam int CNT_W = 13;
    localparam logic [11:0] RESET_VECTOR = 12'hFFE;
    localparam logic [7:0] PORT_RESET = 8'h00;
    localparam logic [7:0] AR_CTRL0_RESET = 8'h02;
    localparam logic [7:0] AR_MODE_RESET = 8'h00;
    localparam logic [7:0] MISC_RESET = 8'h00;
    localparam logic [7:0] WDOG_RESET = 8'hFE;
    localparam logic [7:0] AR_MODE_ADDR = 8'hD5;
    localparam logic [7:0] AR_CTRL0_ADDR = 8'hD6;
    localparam logic [7:0] MISC_ADDR = 8'hDD;
    localparam logic [7:0] WDOG_ADDR = 8'hD8;
    localparam int OSC_OFF_BIT = 2;
endpackage

// [src/sync2.sv]
// Two-flop level synchroniser
`timescale 1ns/1ns
module sync2 (
    input wire logic clk, // Clock
    input wire logic rst, // Sync reset, active high
    input wire logic rst_val, // Unused; reset always holds 1
    input wire logic d, // Asynchronous level
    output logic q // Synchronised level
);
    logic meta;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta <= 1'b1;
            q <= 1'b1;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end

    logic unused;
    assign unused = rst_val;
endmodule
